// ### src/sdcp_regs.svh
// timing counts, mode field layout and reset value for the sdram command block
`ifndef SDCP_REGS_SVH
`define SDCP_REGS_SVH

// clock period in picoseconds (250 MHz)
`define SDCP_CLK_PS        4000
`define SDCP_CYC_UP(ns)    ((((ns) * 1000) + `SDCP_CLK_PS - 1) / `SDCP_CLK_PS)
`define SDCP_CYC_DN(ns)    (((ns) * 1000) / `SDCP_CLK_PS)

`define SDCP_T_RP_NS       20
`define SDCP_T_RC_NS       60
`define SDCP_REFRESH_BUSY_TIME_NS      60
`define SDCP_T_REFI_NS     15600
`define SDCP_MODE_LOCK_CYC 2

`define SDCP_MODE_BL_LSB   0
`define SDCP_MODE_BT_BIT   3
`define SDCP_MODE_CL_LSB   4
`define SDCP_MODE_WBM_BIT  9
`define SDCP_MODE_RST      14'h0020

`endif

// ### src/sdcp_pkg.sv
// types shared by the sdram command block
`default_nettype none
package sdcp_pkg;

    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        cke;
        logic [1:0]  dqm;
        logic [13:0] addr;
    } sdcp_pins_t;

    typedef enum logic [3:0] {
        CMD_NOP       = 4'h0,
        CMD_MODE_LOAD = 4'h1,
        CMD_ACTIVATE  = 4'h2,
        CMD_PRECHARGE = 4'h3,
        CMD_WRITE     = 4'h4,
        CMD_READ      = 4'h5,
        CMD_REFRESH   = 4'h6,
        CMD_SELF_REF  = 4'h7,
        CMD_STOP      = 4'h8
    } sdcp_cmd_t;

    typedef enum logic [1:0] {
        ST_RUN        = 2'h0,
        ST_POWER_DOWN = 2'h1,
        ST_SELF_REF   = 2'h2
    } sdcp_state_t;

    typedef struct packed {
        logic        open;
        logic        busy;
        logic [11:0] row;
    } sdcp_bank_t;

endpackage
`default_nettype wire

// ### src/sdcp_bank.sv
// one bank: open/idle state, open row and precharge lockout
`timescale 1ns/1ps
`default_nettype none
module sdcp_bank
    import sdcp_pkg::*;
#(
    parameter logic [7:0] RP_CYC = 8'h05
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        activate,
    input  wire logic        precharge,
    input  wire logic [11:0] row_in,
    output var  sdcp_bank_t  state
);

    logic [7:0]  cnt;
    logic        open;
    logic [11:0] row;

    // one driver for the whole struct keeps the port a single variable
    assign state = '{open: open, busy: cnt != 8'h00, row: row};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            open <= 1'b0;
            row  <= 12'h000;
            cnt  <= 8'h00;
        end else if (precharge) begin
            open <= 1'b0;
            cnt  <= RP_CYC - 8'h01;  // R04
        end else if (activate && cnt == 8'h00 && !open) begin
            open <= 1'b1;  // R02
            row  <= row_in;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end

    a_pre_lockout: assert property (@(posedge mclk) disable iff (!rst_n)  // R04
        precharge |=> (!state.open)[*5])
        else $error("bank reopened inside precharge period");

endmodule
`default_nettype wire

// ### src/sdcp_mem.sv
// storage array with byte write enables and a registered read port
`timescale 1ns/1ps
`default_nettype none
module sdcp_mem #(
    parameter int AW = 13,
    parameter int DW = 16
) (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            we,
    input  wire logic [DW/8-1:0] be,
    input  wire logic [AW-1:0]   addr,
    input  wire logic [DW-1:0]   wdata,
    input  wire logic            re,
    output logic      [DW-1:0]   rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge mclk) begin
        for (int i = 0; i < DW / 8; i++) begin
            if (we && be[i])
                mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            rdata <= '0;
        else if (re)
            rdata <= mem[addr];
    end

endmodule
`default_nettype wire

// ### src/sdcp_sdram.sv
// sdram command decoder, bank tracking, burst engine and data path
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Overview of operation
// R01: mode load only when idle; two-clock lockout
// R02: activate opens addressed row in addressed bank
// R03: precharge closes one bank, or all
// R04: no activate during bank precharge period
// R05: write latches column, data from same edge
// R06: read data appears after column latency
// R07: counter refresh uses internal row, banks idle
// R08: refresh cycle period blocks all commands
// R09: refresh busy time blocks commands, no precharge
// R10: self refresh while clock gate low, outputs off
// R11: self refresh exit blocks commands for busy time
// R12: burst stop ends any read or write burst
// R13: no-operation changes nothing
// R14: clock gate acts one clock later
// R15: byte mask: reads two clocks, writes same clock
// R16: column command may interrupt burst next clock
// R17: controller leaves gap between read and write data
// R18: controller masks words cut by precharge
// R19: precharge or stop drains latency minus one words
// R20: no column command during auto-precharge burst
// R21: stopped write keeps words before stop only
// R22: track active versus precharge power-down
// R23: mode load captures address bits 13..0
// R24: controller refreshes only idle, awake device
// R25: controller refreshes every 15.6 us on average
// R26: bank states and lockouts reject illegal commands
// ****************************************************************
`include "sdcp_regs.svh"
module sdcp_sdram
    import sdcp_pkg::*;
#(
    parameter int ROW_BITS = 2
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire sdcp_pins_t  pins,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [1:0]  dq_oe,
    output logic      [13:0] mode,
    output logic      [3:0]  bank_open,
    output logic             lockout,
    output logic             self_refresh,
    output logic             power_down,
    output logic             pd_active,
    output logic      [11:0] refresh_row,
    output logic             cmd_rejected
);

    // ****************************************************************
    // constants
    // ****************************************************************
    localparam int AW = 2 + ROW_BITS + 9;
    localparam logic [7:0] RP_CYC    = 8'(`SDCP_CYC_UP(`SDCP_T_RP_NS));
    localparam logic [7:0] RC_CYC    = 8'(`SDCP_CYC_UP(`SDCP_T_RC_NS));
    localparam logic [7:0] RFC_CYC   = 8'(`SDCP_CYC_UP(`SDCP_REFRESH_BUSY_TIME_NS));
    localparam logic [7:0] MODE_LOCK = 8'(`SDCP_MODE_LOCK_CYC);
    localparam logic [7:0] REF_LOCK  = (RC_CYC > RFC_CYC ? RC_CYC : RFC_CYC) - 8'h01;
    localparam logic [7:0] EXIT_LOCK = RFC_CYC - 8'h01;
    localparam logic [11:0] REFI_LAST = 12'(`SDCP_CYC_DN(`SDCP_T_REFI_NS) - 1);
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic sdcp_cmd_t decode(input sdcp_pins_t p);
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h0:    return CMD_MODE_LOAD;
            3'h3:    return CMD_ACTIVATE;
            3'h2:    return CMD_PRECHARGE;
            3'h4:    return CMD_WRITE;
            3'h5:    return CMD_READ;
            3'h1:    return p.cke ? CMD_REFRESH : CMD_SELF_REF;
            3'h6:    return CMD_STOP;
            default: return CMD_NOP;
        endcase
    endfunction

    function automatic logic [8:0] bl_mask(input logic [2:0] code, input logic single);
        if (single)
            return 9'h000;
        case (code)
            3'h1:    return 9'h001;
            3'h2:    return 9'h003;
            3'h3:    return 9'h007;
            3'h7:    return 9'h1ff;
            default: return 9'h000;
        endcase
    endfunction

    // burst wraps inside the aligned block given by the length mask
    function automatic logic [8:0] col_at(input logic [8:0] s, input logic [8:0] k,
                                          input logic [8:0] m, input logic il);
        logic [8:0] w;
        w = il ? (s ^ k) : (s + k);
        return (s & ~m) | (w & m);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    sdcp_cmd_t     cmd;
    sdcp_state_t   state;
    sdcp_state_t   next_state;
    sdcp_bank_t    bank_st [4];
    logic          cke_q;
    logic [7:0]    lock_cnt;
    logic [7:0]    next_lock;
    logic [3:0]    open_v;
    logic [3:0]    busy_v;
    logic          bst_on;
    logic          bst_wr;
    logic          bst_ap;
    logic [1:0]    bst_bank;
    logic [8:0]    bst_start;
    logic [8:0]    bst_k;
    logic [8:0]    bst_mask;
    logic          s0_v;
    logic          s1_v;
    logic          out_v;
    logic [15:0]   s1_d;
    logic [15:0]   m_rdata;
    logic [1:0]    dqm_d1;
    logic [1:0]    dqm_d2;
    logic [11:0]   sref_tmr;
    // ****************************************************************
    // command decode and acceptance
    // ****************************************************************
    assign cmd = decode(pins);
    wire [1:0] ba       = pins.addr[13:12];
    wire [2:0] cas_lat  = mode[`SDCP_MODE_CL_LSB +: 3];
    wire       cl3      = cas_lat == 3'h3;
    wire       il       = mode[`SDCP_MODE_BT_BIT];
    wire [8:0] rd_mask  = bl_mask(mode[`SDCP_MODE_BL_LSB +: 3], 1'b0);
    wire [8:0] wr_mask  = bl_mask(mode[`SDCP_MODE_BL_LSB +: 3], mode[`SDCP_MODE_WBM_BIT]);
    wire       clk_on   = cke_q;  // R14
    wire       live     = clk_on && !pins.cs_n && state == ST_RUN;
    wire       go       = live && lock_cnt == 8'h00;  // R08 R09 R11
    wire       all_idle = open_v == 4'h0 && busy_v == 4'h0;
    wire       col_ok   = open_v[ba] && !(bst_on && bst_ap);  // R20 R26
    wire       acc_mode = go && cmd == CMD_MODE_LOAD && all_idle;  // R01
    wire       acc_act  = go && cmd == CMD_ACTIVATE && !open_v[ba] && !busy_v[ba];  // R02 R04
    wire       acc_pre  = go && cmd == CMD_PRECHARGE;
    wire       acc_wr   = go && cmd == CMD_WRITE && col_ok;
    wire       acc_rd   = go && cmd == CMD_READ && col_ok;
    wire       acc_ref  = go && cmd == CMD_REFRESH && all_idle;  // R07
    wire       acc_sref = go && cmd == CMD_SELF_REF && all_idle;  // R10
    wire       acc_stop = go && cmd == CMD_STOP;
    wire       acc_any  = acc_mode | acc_act | acc_pre | acc_wr | acc_rd | acc_ref | acc_sref | acc_stop;
    wire       rejected = live && cmd != CMD_NOP && !acc_any;  // R26
    // ****************************************************************
    // burst control
    // ****************************************************************
    wire       pre_hit  = acc_pre && (pins.addr[10] || ba == bst_bank);
    wire       cut      = acc_stop || acc_rd || acc_wr || pre_hit;  // R12 R16 R21
    wire       step     = bst_on && clk_on && !cut;
    wire       last     = step && bst_k == bst_mask;
    wire       ap_now   = acc_wr && pins.addr[10] && wr_mask == 9'h000;
    wire       ap_fire  = (last && bst_ap) || ap_now;
    wire [1:0] ap_bank  = ap_now ? ba : bst_bank;
    wire       wr_now   = acc_wr || (step && bst_wr);  // R05
    // a stop or precharge still fetches the word at its own edge
    wire       rd_now   = bst_on && clk_on && !bst_wr && !acc_wr;  // R06 R19
    // ****************************************************************
    // memory access
    // ****************************************************************
    wire [8:0]    cur_col = col_at(bst_start, bst_k, bst_mask, il);
    wire [1:0]    m_bank  = acc_wr ? ba : bst_bank;
    wire [11:0]   m_row   = bank_st[m_bank].row;
    wire [8:0]    m_col   = acc_wr ? pins.addr[8:0] : cur_col;
    wire [AW-1:0] m_addr  = {m_bank, m_row[ROW_BITS-1:0], m_col};
    sdcp_mem #(
        .AW (AW),
        .DW (16)
    ) u_mem (
        .mclk  (mclk),
        .rst_n (rst_n),
        .we    (wr_now),
        .be    (~pins.dqm),  // R15
        .addr  (m_addr),
        .wdata (dq_in),
        .re    (rd_now),
        .rdata (m_rdata)
    );
    // ****************************************************************
    // banks
    // ****************************************************************
    for (genvar b = 0; b < 4; b++) begin : g_bank
        wire [1:0] bid = 2'(b);
        sdcp_bank #(
            .RP_CYC (RP_CYC)
        ) u_bank (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .activate  (acc_act && ba == bid),
            .precharge ((acc_pre && (pins.addr[10] || ba == bid)) || (ap_fire && ap_bank == bid)),  // R03
            .row_in    (pins.addr[11:0]),
            .state     (bank_st[b])
        );
        assign open_v[b] = bank_st[b].open;
        assign busy_v[b] = bank_st[b].busy;
    end
    assign bank_open    = open_v;
    assign lockout      = lock_cnt != 8'h00;
    assign self_refresh = state == ST_SELF_REF;
    assign power_down   = state == ST_POWER_DOWN;
    // ****************************************************************
    // power state and lockout
    // ****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (acc_sref)
                    next_state = ST_SELF_REF;  // R10
                else if (clk_on && !pins.cke && !bst_on && !out_v)
                    next_state = ST_POWER_DOWN;
            end
            ST_POWER_DOWN: begin
                if (pins.cke)
                    next_state = ST_RUN;
            end
            ST_SELF_REF: begin
                if (pins.cke)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end
    always_comb begin
        next_lock = lockout ? lock_cnt - 8'h01 : 8'h00;
        if (acc_mode)
            next_lock = MODE_LOCK;  // R01
        else if (acc_ref)
            next_lock = REF_LOCK;  // R08 R09
        else if (state == ST_SELF_REF && pins.cke)
            next_lock = EXIT_LOCK;  // R11
    end
    // with a burst running, a low clock gate is a suspend, not a power-down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cke_q        <= 1'b0;
            state        <= ST_RUN;
            lock_cnt     <= 8'h00;
            mode         <= `SDCP_MODE_RST;
            cmd_rejected <= 1'b0;
        end else begin
            cke_q        <= pins.cke;  // R14
            state        <= next_state;
            lock_cnt     <= next_lock;
            cmd_rejected <= rejected;
            if (acc_mode)
                mode <= pins.addr;  // R23
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            pd_active <= 1'b0;
        else if (state == ST_RUN && next_state == ST_POWER_DOWN)
            pd_active <= |open_v;  // R22
    end
    // ****************************************************************
    // refresh row counter and self refresh timer
    // ****************************************************************
    wire sref_tick = state == ST_SELF_REF && sref_tmr == REFI_LAST;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_row <= 12'h000;
            sref_tmr    <= 12'h000;
        end else begin
            if (acc_ref || sref_tick)
                refresh_row <= refresh_row + 12'h001;  // R07 R10
            sref_tmr <= (state == ST_SELF_REF && !sref_tick) ? sref_tmr + 12'h001 : 12'h000;
        end
    end
    // ****************************************************************
    // burst engine
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bst_on    <= 1'b0;
            bst_wr    <= 1'b0;
            bst_ap    <= 1'b0;
            bst_bank  <= 2'h0;
            bst_start <= 9'h000;
            bst_k     <= 9'h000;
            bst_mask  <= 9'h000;
        end else if (acc_wr || acc_rd) begin
            bst_on    <= acc_rd || wr_mask != 9'h000;  // R16
            bst_wr    <= acc_wr;
            bst_ap    <= pins.addr[10];
            bst_bank  <= ba;
            bst_start <= pins.addr[8:0];
            bst_k     <= acc_wr ? 9'h001 : 9'h000;
            bst_mask  <= acc_wr ? wr_mask : rd_mask;
        end else if (cut || last) begin
            bst_on <= 1'b0;  // R12 R19
        end else if (step) begin
            bst_k <= bst_k + 9'h001;
        end
    end
    // ****************************************************************
    // read pipeline and output mask
    // ****************************************************************
    // words already fetched keep flowing after a stop or precharge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s0_v   <= 1'b0;
            s1_v   <= 1'b0;
            s1_d   <= 16'h0000;
            out_v  <= 1'b0;
            dq_out <= 16'h0000;
            dqm_d1 <= 2'h0;
            dqm_d2 <= 2'h0;
            dq_oe  <= 2'h0;
        end else if (state == ST_SELF_REF) begin
            out_v <= 1'b0;
            dq_oe <= 2'h0;  // R10
        end else if (clk_on) begin
            s0_v   <= rd_now;  // R19
            s1_v   <= s0_v;
            s1_d   <= m_rdata;
            out_v  <= cl3 ? s1_v : s0_v;  // R06
            dq_out <= cl3 ? s1_d : m_rdata;
            dqm_d1 <= pins.dqm;
            dqm_d2 <= dqm_d1;
            dq_oe  <= (cl3 ? s1_v : s0_v) ? ~dqm_d2 : 2'h0;  // R15
        end
    end
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_mode_lock: assert property (acc_mode |=> (!acc_any)[*2])  // R01
        else $error("command accepted during mode load lockout");
    a_mode_capture: assert property (acc_mode |=> mode == $past(pins.addr))  // R23
        else $error("mode register not loaded from address");
    a_act_opens: assert property (acc_act |=> bank_open[$past(ba)])  // R02
        else $error("activate did not open bank");
    a_pre_all: assert property (acc_pre && pins.addr[10] |=> bank_open == 4'h0)  // R03
        else $error("precharge all left a bank open");
    a_ref_lock: assert property (acc_ref |=> lockout[*8])  // R08
        else $error("refresh lockout too short");
    a_read_cl2: assert property ((acc_rd && cas_lat == 3'h2) ##1 (clk_on && !cut)[*2] |=> out_v)  // R06
        else $error("read data missing at latency two");
    a_stop_ends: assert property (acc_stop |-> !wr_now ##1 !bst_on)  // R21
        else $error("burst continued past stop");
    a_nop_quiet: assert property (go && cmd == CMD_NOP && !ap_fire |=> $stable(bank_open) && $stable(mode))  // R13
        else $error("no-operation changed state");
    a_sref_hiz: assert property (state == ST_SELF_REF |=> dq_oe == 2'h0)  // R10
        else $error("outputs driven in self refresh");
    a_dqm_read: assert property ($past(pins.dqm[0], 2) && clk_on && $past(clk_on) && $past(clk_on, 2)
                                 |=> !dq_oe[0])  // R15
        else $error("masked read byte driven");
    a_pd_kind: assert property (state == ST_RUN && next_state == ST_POWER_DOWN
                                |=> pd_active == $past(|open_v))  // R22
        else $error("power-down kind wrong");

endmodule
`default_nettype wire

// ### dv/sdcp_ctrl_model.sv
// controller-side model that drives the sdram command and write-data lines
`timescale 1ns/1ps
`default_nettype none
module sdcp_ctrl_model
    import sdcp_pkg::*;
(
    input  wire logic       mclk,
    output var  sdcp_pins_t pins,
    output var  logic [15:0] dq_in
);
    initial begin
        pins  = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, dqm: 2'h0, addr: 14'h0000};
        dq_in = 16'h0000;
    end
    // ****************************************************************
    // command issue
    // ****************************************************************
    // set up after a falling edge, held through exactly one rising edge
    // never interrupts auto-precharge bursts and keeps a gap before write data
    task automatic send(input logic [3:0] s, input logic [13:0] a, input logic [15:0] d, input logic [1:0] m);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = s;
        pins.addr = a;
        pins.dqm  = m;
        dq_in     = d;
        @(negedge mclk);
    endtask
    // released lines toggle so a stale word never looks valid
    // every other idle cycle is deselected with a mode-load code beneath, which must be ignored
    task automatic idle(input int n);
        repeat (n) send(pins.cs_n ? 4'h7 : 4'h8, ~pins.addr, ~dq_in, 2'h0);
    endtask
    // refresh only with clock gate high the cycle before; run is far shorter than the refresh interval
    task automatic set_cke(input logic v);
        pins.cke = v;
    endtask
endmodule
`default_nettype wire

// ### dv/sdcp_sdram_tb.sv
// self-checking bench for the sdram command block
`timescale 1ns/1ps
`default_nettype none
module sdcp_sdram_tb;
    import sdcp_pkg::*;
    localparam logic [3:0] C_MODE = 4'h0;
    localparam logic [3:0] C_ACT  = 4'h3;
    localparam logic [3:0] C_PRE  = 4'h2;
    localparam logic [3:0] C_WR   = 4'h4;
    localparam logic [3:0] C_RD   = 4'h5;
    localparam logic [3:0] C_REF  = 4'h1;
    localparam logic [3:0] C_STOP = 4'h6;
    localparam logic [3:0] C_NOP  = 4'h7;
    logic        mclk  = 1'b0;
    logic        rst_n = 1'b0;
    sdcp_pins_t  pins;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    logic [1:0]  dq_oe;
    logic [13:0] mode;
    logic [3:0]  bank_open;
    logic        lockout;
    logic        self_refresh;
    logic        power_down;
    logic        pd_active;
    logic [11:0] refresh_row;
    logic        cmd_rejected;
    int          err_total = 0;
    int          cmp_count = 0;
    logic [15:0] exp_rd [4] = '{16'h2220, 16'h2211, 16'h1112, 16'h1113};

    always #2 mclk = ~mclk;

    sdcp_ctrl_model m_u (
        .mclk  (mclk),
        .pins  (pins),
        .dq_in (dq_in)
    );
    sdcp_sdram #(
        .ROW_BITS (2)
    ) dut_u (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .pins         (pins),
        .dq_in        (dq_in),
        .dq_out       (dq_out),
        .dq_oe        (dq_oe),
        .mode         (mode),
        .bank_open    (bank_open),
        .lockout      (lockout),
        .self_refresh (self_refresh),
        .power_down   (power_down),
        .pd_active    (pd_active),
        .refresh_row  (refresh_row),
        .cmd_rejected (cmd_rejected)
    );

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        cmp_count++;
        if (got !== ex) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // the whole sequence needs about 96 cycles; this allows five times that
    initial begin
        #2000;
        err_total++;
        $display("unexpected watchdog: expected 0, seen 1");
        end_sim();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        m_u.idle(2);
        chk("mode", 16'h0020, 16'(mode));
        chk("bank_open", 16'h0000, 16'(bank_open));
        m_u.send(C_MODE, 14'h0022, 16'h0000, 2'h0);
        chk("mode", 16'h0022, 16'(mode));
        chk("lockout", 16'h0001, 16'(lockout));
        m_u.send(C_ACT, 14'h0000, 16'h0000, 2'h0);
        chk("cmd_rejected", 16'h0001, 16'(cmd_rejected));
        m_u.idle(2);
        chk("bank_open", 16'h0000, 16'(bank_open));
        m_u.send(C_ACT, 14'h1005, 16'h0000, 2'h0);
        chk("bank_open", 16'h0002, 16'(bank_open));
        // full burst, then a masked and stopped burst over it
        for (int i = 0; i < 4; i++) begin
            m_u.send((i == 0) ? C_WR : C_NOP, 14'h1004, 16'(16'h1110 + i), 2'h0);
        end
        m_u.send(C_WR, 14'h1004, 16'h2220, 2'h0);
        m_u.send(C_NOP, 14'h1004, 16'h2221, 2'h1);
        m_u.send(C_STOP, 14'h1004, 16'h2222, 2'h0);
        m_u.send(C_RD, 14'h1004, 16'h0000, 2'h0);
        m_u.idle(1);
        for (int i = 0; i < 4; i++) begin
            m_u.idle(1);
            chk("dq_out", exp_rd[i], dq_out);
            if (i == 0) chk("dq_oe", 16'h0003, 16'(dq_oe));
        end
        // stopped read drains one word at latency two
        m_u.send(C_RD, 14'h1004, 16'h0000, 2'h0);
        m_u.send(C_STOP, 14'h1004, 16'h0000, 2'h0);
        m_u.idle(1);
        chk("dq_out", 16'h2220, dq_out);
        chk("dq_oe", 16'h0003, 16'(dq_oe));
        m_u.idle(1);
        chk("dq_oe", 16'h0000, 16'(dq_oe));
        m_u.set_cke(1'b0);
        m_u.idle(3);
        chk("power_down", 16'h0001, 16'(power_down));
        chk("pd_active", 16'h0001, 16'(pd_active));
        m_u.set_cke(1'b1);
        m_u.idle(3);
        chk("power_down", 16'h0000, 16'(power_down));
        m_u.send(C_ACT, 14'h2007, 16'h0000, 2'h0);
        chk("bank_open", 16'h0006, 16'(bank_open));
        m_u.send(C_PRE, 14'h0400, 16'h0000, 2'h0);
        chk("bank_open", 16'h0000, 16'(bank_open));
        m_u.send(C_ACT, 14'h1005, 16'h0000, 2'h0);
        chk("cmd_rejected", 16'h0001, 16'(cmd_rejected));
        m_u.idle(3);
        m_u.send(C_ACT, 14'h1005, 16'h0000, 2'h0);
        chk("bank_open", 16'h0002, 16'(bank_open));
        m_u.send(C_ACT, 14'h3001, 16'h0000, 2'h0);
        m_u.send(C_PRE, 14'h1000, 16'h0000, 2'h0);
        chk("bank_open", 16'h0008, 16'(bank_open));
        m_u.send(C_PRE, 14'h0400, 16'h0000, 2'h0);
        m_u.idle(5);
        m_u.send(C_REF, 14'h0000, 16'h0000, 2'h0);
        chk("lockout", 16'h0001, 16'(lockout));
        chk("bank_open", 16'h0000, 16'(bank_open));
        chk("refresh_row", 16'h0001, 16'(refresh_row));
        m_u.send(C_ACT, 14'h0000, 16'h0000, 2'h0);
        chk("cmd_rejected", 16'h0001, 16'(cmd_rejected));
        m_u.idle(13);
        m_u.send(C_ACT, 14'h0000, 16'h0000, 2'h0);
        chk("bank_open", 16'h0001, 16'(bank_open));
        m_u.send(C_PRE, 14'h0400, 16'h0000, 2'h0);
        m_u.idle(5);
        m_u.set_cke(1'b0);
        m_u.send(C_REF, 14'h0000, 16'h0000, 2'h0);
        m_u.idle(2);
        chk("self_refresh", 16'h0001, 16'(self_refresh));
        chk("dq_oe", 16'h0000, 16'(dq_oe));
        m_u.set_cke(1'b1);
        m_u.idle(2);
        chk("self_refresh", 16'h0000, 16'(self_refresh));
        chk("lockout", 16'h0001, 16'(lockout));
        m_u.send(C_ACT, 14'h0000, 16'h0000, 2'h0);
        chk("cmd_rejected", 16'h0001, 16'(cmd_rejected));
        m_u.idle(15);
        chk("mode", 16'h0022, 16'(mode));
        end_sim();
    end
endmodule
`default_nettype wire
